// *** pkg/tcc_map.svh ***
// Register map, field layout and code constants of the timer count control
//
// Operation
// (R01) Second channel control register ignored in reset-synchronous PWM or PWM3.
// (R02) Clear select 000: counter free-runs, never cleared by match or capture.
// (R03) Clear codes 001,010,101,110 clear on register A,B,C,D; 100,111 reserved.
// (R04) Clear code 011 clears this counter together with the other counter.
// (R05) Synchronous clear acts only while the channel sync bit is set.
// (R06) Software sets clear code 001 in PWM and reset-synchronous PWM.
// (R07) Software sets channel 0 clear code 000 in complementary PWM.
// (R08) Edge field: 00 rising, 01 falling, 10 both edges; 11 reserved.
// (R09) Edge selection applies only to external pin source with input enabled.
// (R10) Source 101 is the external pin, only with input enable set.
// (R11) Source 000 is system clock, or oscillator clock when option bit set.
// (R12) Software avoids divided sources 001 to 100 while option bit set.
// (R13) Software moves system clock to oscillator before enabling the timer.
// (R14) Software disables the timer before moving system clock elsewhere.
// (R15) Control registers reset to zero; read undefined when option set, disabled.
// (R16) Counter adds one on each active event of the selected source.
`ifndef TCC_MAP_SVH
`define TCC_MAP_SVH

// ============================================================
// Register offsets (byte addresses)
`define TCC_ADR_CR0 20'hf0270
`define TCC_ADR_CR1 20'hf0280
`define TCC_ADR_MODE 20'hf0290
`define TCC_ADR_FUNC 20'hf0294
`define TCC_ADR_START 20'hf0298
`define TCC_ADR_CNT0 20'hf029c
`define TCC_ADR_CNT1 20'hf02a0

// ============================================================
// Reset values
`define TCC_CR_RST 8'h00
`define TCC_MODE_RST 4'h0
`define TCC_CNT_RST 16'h0000
`define TCC_UNDEF_READ 8'hff

// ============================================================
// Field positions
`define TCC_CLR_HI 7
`define TCC_CLR_LO 5
`define TCC_EDGE_HI 4
`define TCC_EDGE_LO 3
`define TCC_SRC_HI 2
`define TCC_SRC_LO 0
`define TCC_MODE_SYNC 0
`define TCC_MODE_PWM_HI 3
`define TCC_MODE_PWM_LO 1
`define TCC_FUNC_EXTEN 0

// ============================================================
// Clear select codes
`define TCC_CLR_FREE 3'h0
`define TCC_CLR_A 3'h1
`define TCC_CLR_B 3'h2
`define TCC_CLR_SYNC 3'h3
`define TCC_CLR_C 3'h5
`define TCC_CLR_D 3'h6

// ============================================================
// Count source and edge codes
`define TCC_SRC_CLK 3'h0
`define TCC_SRC_DIV2 3'h1
`define TCC_SRC_DIV4 3'h2
`define TCC_SRC_DIV8 3'h3
`define TCC_SRC_DIV32 3'h4
`define TCC_SRC_EXT 3'h5
`define TCC_EDGE_RISE 2'h0
`define TCC_EDGE_FALL 2'h1
`define TCC_EDGE_BOTH 2'h2

// ============================================================
// Prescaler taps
`define TCC_PRE_MAX 5'h1f
`define TCC_PRE_M2 5'h01
`define TCC_PRE_M4 5'h03
`define TCC_PRE_M8 5'h07
`define TCC_PRE_M32 5'h1f

`endif

// *** pkg/tcc_pkg.sv ***
// Types shared by the timer count control
package tcc_pkg;

  // Counter operating mode, Gray-coded along the usual path
  typedef enum logic [2:0] {
    TCC_MODE_TIMER = 3'h0,
    TCC_MODE_PWM = 3'h1,
    TCC_MODE_RSPWM = 3'h3,
    TCC_MODE_CPWM = 3'h2,
    TCC_MODE_PWM3 = 3'h6
  } tcc_mode_type;

  // Match pulses, four general registers per channel
  typedef logic [1:0][3:0] tcc_match_type;

  typedef logic [15:0] tcc_count_type;

endpackage

// *** core/tcc_timer_ctrl.sv ***
// Count control of two channel counters with a Wishbone register port
`timescale 1ns/1ns
`default_nettype none
`include "tcc_map.svh"

module tcc_timer_ctrl #(
  parameter int ADR_W = 20,
  parameter int CNT_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire tcc_pkg::tcc_match_type match_i,
  input wire logic ext_count_clock_pin_i,
  input wire logic oscillator_option_bit_i,
  input wire logic timer_module_enable_i,
  input wire logic hoco_tick_i,
  output logic [CNT_W-1:0] channel0_counter_o,
  output logic [CNT_W-1:0] channel1_counter_o
);
  import tcc_pkg::*;

  // ============================================================
  // Registers and state
  logic [7:0] count_control_ch0;
  logic [7:0] count_control_ch1;
  logic channel_sync_bit;
  tcc_mode_type pwm_mode;
  logic ext_clock_input_enable;
  logic [1:0] start;
  logic osc_opt;
  logic strap_done;
  logic [4:0] prescale;
  logic ext_meta;
  logic ext_sync;
  logic ext_prev;
  logic [CNT_W-1:0] cnt [2];
  logic [7:0] eff_cr [2];
  logic [1:0] tick;
  logic [1:0] clr_own;
  logic [1:0] clr;
  logic [1:0] run;
  logic ext_rise;
  logic ext_fall;
  logic acc;
  logic wr;
  logic lane0;
  logic undef_rd;
  logic [31:0] next_dat;

  function automatic logic [2:0] clr_field(input logic [7:0] cr);
    clr_field = cr[`TCC_CLR_HI:`TCC_CLR_LO];
  endfunction

  function automatic logic [2:0] src_field(input logic [7:0] cr);
    src_field = cr[`TCC_SRC_HI:`TCC_SRC_LO];
  endfunction

  function automatic logic [1:0] edge_field(input logic [7:0] cr);
    edge_field = cr[`TCC_EDGE_HI:`TCC_EDGE_LO];
  endfunction

  // ============================================================
  // Bus access decode
  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = acc && wb_we_i;
  assign lane0 = wb_sel_i[0];
  assign undef_rd = osc_opt && !timer_module_enable_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_control_ch0 <= `TCC_CR_RST; // see (R15)
      count_control_ch1 <= `TCC_CR_RST; // see (R15)
    end else if (wr && lane0) begin
      if (wb_adr_i == `TCC_ADR_CR0) begin
        count_control_ch0 <= wb_dat_i[7:0];
      end
      if (wb_adr_i == `TCC_ADR_CR1) begin
        count_control_ch1 <= wb_dat_i[7:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      channel_sync_bit <= 1'b0;
      pwm_mode <= TCC_MODE_TIMER;
      ext_clock_input_enable <= 1'b0;
      start <= 2'h0;
    end else if (wr && lane0) begin
      if (wb_adr_i == `TCC_ADR_MODE) begin
        channel_sync_bit <= wb_dat_i[`TCC_MODE_SYNC];
        pwm_mode <= tcc_mode_type'(
          wb_dat_i[`TCC_MODE_PWM_HI:`TCC_MODE_PWM_LO]);
      end
      if (wb_adr_i == `TCC_ADR_FUNC) begin
        ext_clock_input_enable <= wb_dat_i[`TCC_FUNC_EXTEN];
      end
      if (wb_adr_i == `TCC_ADR_START) begin
        start <= wb_dat_i[1:0];
      end
    end
  end

  // Read mux; unmapped addresses read zero and still get an ack
  always_comb begin
    next_dat = 32'h0000_0000;
    case (wb_adr_i)
      `TCC_ADR_CR0: begin
        next_dat[7:0] = undef_rd ? `TCC_UNDEF_READ : count_control_ch0;
      end
      `TCC_ADR_CR1: begin
        next_dat[7:0] = undef_rd ? `TCC_UNDEF_READ : count_control_ch1;
      end
      `TCC_ADR_MODE: begin
        next_dat[`TCC_MODE_SYNC] = channel_sync_bit;
        next_dat[`TCC_MODE_PWM_HI:`TCC_MODE_PWM_LO] = pwm_mode;
      end
      `TCC_ADR_FUNC: begin
        next_dat[`TCC_FUNC_EXTEN] = ext_clock_input_enable;
      end
      `TCC_ADR_START: begin
        next_dat[1:0] = start;
      end
      `TCC_ADR_CNT0: begin
        next_dat[CNT_W-1:0] = cnt[0];
      end
      `TCC_ADR_CNT1: begin
        next_dat[CNT_W-1:0] = cnt[1];
      end
      default: begin
        next_dat = 32'h0000_0000;
      end
    endcase
  end

  // Fixed one-wait answer keeps the decode off the ack path
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= acc;
      wb_dat_o <= acc ? next_dat : 32'h0000_0000;
    end
  end

  // ============================================================
  // Oscillator option strap, caught once after reset release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_opt <= 1'b0;
      strap_done <= 1'b0;
    end else if (!strap_done) begin
      osc_opt <= oscillator_option_bit_i;
      strap_done <= 1'b1;
    end
  end

  // ============================================================
  // Prescaler and external pin edge detect
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prescale <= 5'h00;
    end else begin
      prescale <= prescale + 5'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_meta <= ext_count_clock_pin_i;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  assign ext_rise = ext_sync && !ext_prev;
  assign ext_fall = !ext_sync && ext_prev;

  // ============================================================
  // Per-channel source, clear and counter
  // Channel 1 follows channel 0 settings in the shared-counter modes
  assign eff_cr[0] = count_control_ch0;
  assign eff_cr[1] = (pwm_mode == TCC_MODE_RSPWM ||
                      pwm_mode == TCC_MODE_PWM3) ?
                     count_control_ch0 : count_control_ch1; // see (R01)

  // Divided sources under the option strap are the software's problem
  function automatic logic src_tick(input logic [7:0] cr);
    logic [1:0] e;
    e = edge_field(cr);
    src_tick = 1'b0;
    case (src_field(cr))
      `TCC_SRC_CLK: src_tick = osc_opt ? hoco_tick_i : 1'b1; // see (R11)
      `TCC_SRC_DIV2: src_tick = (prescale[0] == `TCC_PRE_M2);
      `TCC_SRC_DIV4: src_tick = (prescale[1:0] == `TCC_PRE_M4);
      `TCC_SRC_DIV8: src_tick = (prescale[2:0] == `TCC_PRE_M8);
      `TCC_SRC_DIV32: src_tick = (prescale == `TCC_PRE_M32);
      `TCC_SRC_EXT: begin
        if (ext_clock_input_enable) begin // see (R09) see (R10)
          case (e)
            `TCC_EDGE_RISE: src_tick = ext_rise; // see (R08)
            `TCC_EDGE_FALL: src_tick = ext_fall; // see (R08)
            `TCC_EDGE_BOTH: src_tick = ext_rise || ext_fall; // see (R08)
            default: src_tick = 1'b0;
          endcase
        end
      end
      default: src_tick = 1'b0;
    endcase
  endfunction

  function automatic logic own_clear(input logic [7:0] cr,
                                     input logic [3:0] m);
    own_clear = 1'b0;
    case (clr_field(cr))
      `TCC_CLR_A: own_clear = m[0]; // see (R03)
      `TCC_CLR_B: own_clear = m[1]; // see (R03)
      `TCC_CLR_C: own_clear = m[2]; // see (R03)
      `TCC_CLR_D: own_clear = m[3]; // see (R03)
      default: own_clear = 1'b0; // see (R02)
    endcase
  endfunction

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      assign run[ch] = start[ch] && timer_module_enable_i;
      assign tick[ch] = run[ch] && src_tick(eff_cr[ch]);
      assign clr_own[ch] = run[ch] && own_clear(eff_cr[ch], match_i[ch]);
      assign clr[ch] = clr_own[ch] ||
        (channel_sync_bit && // see (R05)
         clr_field(eff_cr[ch]) == `TCC_CLR_SYNC &&
         clr_own[1-ch]); // see (R04)

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          cnt[ch] <= `TCC_CNT_RST;
        end else if (clr[ch]) begin
          cnt[ch] <= `TCC_CNT_RST;
        end else if (tick[ch]) begin
          cnt[ch] <= cnt[ch] + 1'b1; // see (R16)
        end
      end
    end
  endgenerate

  assign channel0_counter_o = cnt[0];
  assign channel1_counter_o = cnt[1];

  // ============================================================
  // Checks
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence s_answer;
    ##1 wb_ack_o ##1 !wb_ack_o;
  endsequence

  a_wb_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    s_req |-> s_answer)
    else $error("bus answer not one cycle after request");

  a_free_run: assert property (@(posedge clk_i) disable iff (rst_i) // see (R02)
    clr_field(eff_cr[0]) == `TCC_CLR_FREE |-> !clr[0])
    else $error("free-running counter was cleared");

  a_match_clear: assert property (@(posedge clk_i) disable iff (rst_i) // see (R03)
    run[0] && clr_field(eff_cr[0]) == `TCC_CLR_B && match_i[0][1]
    |=> channel0_counter_o == `TCC_CNT_RST)
    else $error("register B match did not clear channel 0");

  a_sync_clear: assert property (@(posedge clk_i) disable iff (rst_i) // see (R04)
    channel_sync_bit && clr_own[0] &&
    clr_field(eff_cr[1]) == `TCC_CLR_SYNC
    |=> channel1_counter_o == `TCC_CNT_RST)
    else $error("synchronous clear missed channel 1");

  a_sync_gate: assert property (@(posedge clk_i) disable iff (rst_i) // see (R05)
    !channel_sync_bit && !clr_own[1] |-> !clr[1])
    else $error("sync clear without sync bit");

  a_ch1_shadow: assert property (@(posedge clk_i) disable iff (rst_i) // see (R01)
    (pwm_mode == TCC_MODE_PWM3 || pwm_mode == TCC_MODE_RSPWM) &&
    count_control_ch1 != count_control_ch0 && !clr[1]
    && run[1] && src_field(count_control_ch0) == `TCC_SRC_CLK
    && !osc_opt
    |=> channel1_counter_o == $past(channel1_counter_o) + 1'b1)
    else $error("channel 1 register not ignored");

  a_edge_fall: assert property (@(posedge clk_i) disable iff (rst_i) // see (R08)
    run[0] && !clr[0] && ext_clock_input_enable &&
    src_field(eff_cr[0]) == `TCC_SRC_EXT &&
    edge_field(eff_cr[0]) == `TCC_EDGE_FALL && ext_rise
    |=> $stable(channel0_counter_o))
    else $error("rising edge counted under falling select");

  a_ext_gate: assert property (@(posedge clk_i) disable iff (rst_i) // see (R09) see (R10)
    !ext_clock_input_enable && src_field(eff_cr[0]) == `TCC_SRC_EXT
    && !clr[0] |=> $stable(channel0_counter_o))
    else $error("external source counted while disabled");

  a_sys_tick: assert property (@(posedge clk_i) disable iff (rst_i) // see (R11) see (R16)
    run[0] && !clr[0] && !osc_opt &&
    src_field(eff_cr[0]) == `TCC_SRC_CLK
    |=> channel0_counter_o == $past(channel0_counter_o) + 1'b1)
    else $error("system clock source did not count");

  a_reset_zero: assert property (@(posedge clk_i) // see (R15)
    rst_i |=> count_control_ch0 == `TCC_CR_RST &&
    count_control_ch1 == `TCC_CR_RST)
    else $error("control registers not zero after reset");

endmodule
`default_nettype wire

// *** tb/test_timer_count_control.sv ***
// Self-checking bench for the timer count control block
`timescale 1ns/1ns
`default_nettype none
`include "tcc_map.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end

module test_timer_count_control;
  import tcc_pkg::*;
  logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
  logic [19:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rdat;
  logic [3:0] wb_sel_i;
  tcc_match_type match_i;
  logic ext_count_clock_pin_i, oscillator_option_bit_i;
  logic timer_module_enable_i, hoco_tick_i;
  tcc_count_type channel0_counter_o, channel1_counter_o, a0, a1, b0, b1;
  int err_count = 0;
  int total_checks = 0;

  tcc_timer_ctrl tcc_timer_ctrl_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .match_i(match_i), .ext_count_clock_pin_i(ext_count_clock_pin_i),
    .oscillator_option_bit_i(oscillator_option_bit_i),
    .timer_module_enable_i(timer_module_enable_i),
    .hoco_tick_i(hoco_tick_i), .channel0_counter_o(channel0_counter_o),
    .channel1_counter_o(channel1_counter_o)
  );

  // ============================================================
  // Clock and common tasks
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task end_of_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task bus(input logic w, input logic [19:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    wb_sel_i <= 4'h1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      err_count++;
      end_of_test();
    end
  endtask

  task wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task sample(output tcc_count_type c0, output tcc_count_type c1);
    @(posedge clk_i);
    c0 = channel0_counter_o;
    c1 = channel1_counter_o;
  endtask

  // Counters seen one edge after the match pulse was taken
  task pulse(input int ch, input int idx, output tcc_count_type c0,
             output tcc_count_type c1);
    @(posedge clk_i);
    match_i[ch][idx] <= 1'b1;
    @(posedge clk_i);
    match_i <= '0;
    sample(c0, c1);
  endtask

  task do_reset(input logic strap);
    rst_i <= 1'b1;
    oscillator_option_bit_i <= strap;
    timer_module_enable_i <= ~strap;
    wait_cyc(5);
    rst_i <= 1'b0;
  endtask

  // ============================================================
  // Scenarios
  task test_regs;
    bus(1'b0, `TCC_ADR_CR0, 8'h00);
    `CHK(rdat, 32'h00000000)
    bus(1'b0, `TCC_ADR_CR1, 8'h00);
    `CHK(rdat, 32'h00000000)
    bus(1'b1, `TCC_ADR_CR1, 8'h5a);
    bus(1'b0, `TCC_ADR_CR1, 8'h00);
    `CHK(rdat, 32'h0000005a)
    bus(1'b0, 20'hf0300, 8'h00);
    `CHK(rdat, 32'h00000000)
  endtask

  task test_clear;
    logic [2:0] code [6] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h0, 3'h4};
    bus(1'b1, `TCC_ADR_CR1, 8'h00);
    bus(1'b1, `TCC_ADR_START, 8'h01);
    sample(a0, a1);
    wait_cyc(10);
    sample(b0, b1);
    `CHK(b0 - a0, 16'h000b)
    // Divided sources, strap low; 32 edges cover every prescaler phase
    for (int s = 1; s < 5; s++) begin
      bus(1'b1, `TCC_ADR_CR0, 8'(s));
      sample(a0, a1);
      wait_cyc(31);
      sample(b0, b1);
      `CHK(b0 - a0, (s == 4) ? 16'h1 : (16'h20 >> s))
    end
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, `TCC_ADR_CR0, {code[i], 5'h00});
      pulse(0, (i + 1) % 4, a0, a1);
      `CHK(a0 === 16'h0000, 1'b0)
      if (i < 4) begin
        pulse(0, i, a0, a1);
        `CHK(a0, 16'h0000)
      end
    end
  endtask

  task test_sync;
    bus(1'b1, `TCC_ADR_CR0, 8'h20);
    bus(1'b1, `TCC_ADR_CR1, 8'h60);
    bus(1'b1, `TCC_ADR_START, 8'h03);
    bus(1'b1, `TCC_ADR_MODE, 8'h00);
    pulse(0, 0, a0, a1);
    `CHK(a0, 16'h0000)
    `CHK(a1 === 16'h0000, 1'b0)
    bus(1'b1, `TCC_ADR_MODE, 8'h01);
    pulse(0, 0, a0, a1);
    `CHK(a0, 16'h0000)
    `CHK(a1, 16'h0000)
  endtask

  task test_ext;
    tcc_count_type exp_d [4] = '{16'h1, 16'h1, 16'h2, 16'h0};
    bus(1'b1, `TCC_ADR_MODE, 8'h00);
    bus(1'b1, `TCC_ADR_FUNC, 8'h00);
    bus(1'b1, `TCC_ADR_CR0, 8'h05);
    for (int e = -1; e < 4; e++) begin
      if (e == 0) begin
        bus(1'b1, `TCC_ADR_FUNC, 8'h01);
      end
      if (e >= 0) begin
        bus(1'b1, `TCC_ADR_CR0, 8'h05 | (8'(e) << 3));
      end
      sample(a0, a1);
      ext_count_clock_pin_i <= 1'b1;
      wait_cyc(6);
      ext_count_clock_pin_i <= 1'b0;
      wait_cyc(6);
      sample(b0, b1);
      `CHK(b0 - a0, (e < 0) ? 16'h0 : exp_d[e])
    end
  endtask

  task test_mode;
    bus(1'b1, `TCC_ADR_FUNC, 8'h00);
    bus(1'b1, `TCC_ADR_CR0, 8'h20);
    bus(1'b1, `TCC_ADR_CR1, 8'h05);
    bus(1'b1, `TCC_ADR_MODE, 8'h06);
    sample(a0, a1);
    wait_cyc(7);
    sample(b0, b1);
    `CHK(b1 - a1, 16'h0008)
    // Complementary mode keeps channel 1 on its own register
    bus(1'b1, `TCC_ADR_CR0, 8'h00);
    bus(1'b1, `TCC_ADR_MODE, 8'h04);
    sample(a0, a1);
    wait_cyc(7);
    sample(b0, b1);
    `CHK(b1 - a1, 16'h0000)
  endtask

  task test_strap;
    do_reset(1'b1);
    bus(1'b0, `TCC_ADR_CR0, 8'h00);
    `CHK(rdat, 32'h000000ff)
    timer_module_enable_i <= 1'b1;
    bus(1'b0, `TCC_ADR_CR0, 8'h00);
    `CHK(rdat, 32'h00000000)
    bus(1'b1, `TCC_ADR_START, 8'h01);
    sample(a0, a1);
    repeat (3) begin
      hoco_tick_i <= 1'b1;
      @(posedge clk_i);
      hoco_tick_i <= 1'b0;
      wait_cyc(2);
    end
    sample(b0, b1);
    `CHK(b0 - a0, 16'h0003)
  endtask

  // ============================================================
  // Main sequence
  initial begin
    rst_i = 1'b1;
    wb_adr_i = '0;
    wb_dat_i = '0;
    wb_sel_i = '0;
    wb_we_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    match_i = '0;
    ext_count_clock_pin_i = 1'b0;
    oscillator_option_bit_i = 1'b0;
    timer_module_enable_i = 1'b1;
    hoco_tick_i = 1'b0;
    do_reset(1'b0);
    test_regs();
    test_clear();
    test_sync();
    test_ext();
    test_mode();
    test_strap();
    end_of_test();
  end
endmodule
`default_nettype wire
